/* File: core/isp_ctrl.sv */
// Local design decisions: the register addresses and the strobed register port.
`include "isp_params.svh"
module isp_ctrl #(
    parameter int NPER = 32
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire isp_pkg::isp_bus_t bus_i,
    output logic [15:0] rdata_o,
    input wire logic nmi_pin,
    input wire logic [7:0] irq_pins_n,
    input wire logic brk_match,
    input wire logic dbg_irq_cmd,
    input wire logic [NPER-1:0] periph_req,
    input wire isp_pkg::isp_cpu_in_t cpu_i,
    output isp_pkg::isp_cpu_out_t cpu_o
);
    import isp_pkg::*;

    localparam int NSRC = 11 + NPER;

    // ****************************************
    // parameter check
    // ****************************************
    // peripheral fields live in registers c to j: four per register
    if (NPER < 1 || NPER > 32) begin : g_bad_nper
        $error("NPER must lie in 1 to 32");
    end

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic [1:0] nmi_sy;
        logic nmi_old;
        logic [7:0] irq_s1;
        logic [7:0] irq_s2;
        logic [7:0] irq_old;
        logic brk_old;
        logic dbg_old;
        logic nmi_f;
        logic brk_f;
        logic dbg_f;
        logic [7:0] irq_f;
        logic [7:0] armed;
        logic [9:0][15:0] pri;
        logic [15:0] ctl1;
        logic [15:0] ctl2;
        logic [15:0] rdata;
        isp_cpu_out_t cpu;
    } isp_state_t;

    localparam isp_state_t ST_RST = '0;

    isp_state_t s_q;
    isp_state_t s_d;

    // ****************************************
    // decode helpers
    // ****************************************
    function automatic logic [3:0] pri_of(input logic [9:0][15:0] pri, input int k);
        logic [3:0] r;
        r = pri[k / 4][(3 - (k % 4)) * 4 +: 4];
        return r;
    endfunction : pri_of

    function automatic isp_mode_t pin_mode(input logic [15:0] c1, input logic [15:0] c2,
                                           input int n);
        isp_mode_t m;
        if (!c1[7 - n]) begin
            m = ISP_MD_LOW;
        end else begin
            m = isp_mode_t'(c2[15 - 2 * n -: 2]);
        end
        return m;
    endfunction : pin_mode

    // ****************************************
    // next state
    // ****************************************
    logic take;
    logic [NSRC-1:0] pend;
    logic [4:0] lvl [NSRC];
    logic [4:0] best_lvl;
    logic [5:0] best_src;
    logic found;
    logic nmi_edge;
    logic [15:0] rd_mux;
    logic [7:0] clr_ok;
    isp_mode_t md;

    always_comb begin
        s_d = s_q;
        take = cpu_i.accept && s_q.cpu.valid;
        pend = '0;
        best_lvl = {1'b0, cpu_i.mask_level};
        best_src = '0;
        found = 1'b0;
        nmi_edge = 1'b0;
        rd_mux = 16'h0000;
        clr_ok = 8'h00;
        md = ISP_MD_LOW;
        for (int k = 0; k < NSRC; k++) begin
            lvl[k] = 5'h00;
        end

        // pins pass two flops before anything looks at them
        s_d.nmi_sy = {s_q.nmi_sy[0], nmi_pin};
        s_d.nmi_old = s_q.nmi_sy[1];
        s_d.irq_s1 = irq_pins_n;
        s_d.irq_s2 = s_q.irq_s1;
        s_d.irq_old = s_q.irq_s2;
        s_d.brk_old = brk_match;
        s_d.dbg_old = dbg_irq_cmd;

        // clears come first so that a same-cycle set wins
        if (take && s_q.cpu.src == `ISP_SRC_NMI) begin
            s_d.nmi_f = 1'b0;
        end
        if (take && s_q.cpu.src == `ISP_SRC_BRK) begin
            s_d.brk_f = 1'b0;
        end
        if (take && s_q.cpu.src == `ISP_SRC_DBG) begin
            s_d.dbg_f = 1'b0;
        end
        for (int i = 0; i < `ISP_N_PIN; i++) begin
            clr_ok[i] = bus_i.wr && bus_i.addr == `ISP_A_STAT && !bus_i.wdata[7 - i]
                        && s_q.armed[i];
            if (take && s_q.cpu.src == `ISP_SRC_IRQ0 + 6'(i)) begin
                s_d.irq_f[i] = 1'b0;
                s_d.armed[i] = 1'b0;
            end
            if (clr_ok[i]) begin
                s_d.irq_f[i] = 1'b0;
                s_d.armed[i] = 1'b0;
            end
        end

        // register writes
        if (bus_i.wr) begin
            if (bus_i.addr < 4'(`ISP_N_PRI)) begin
                s_d.pri[bus_i.addr] = bus_i.wdata;
            end else if (bus_i.addr == `ISP_A_CTRL1) begin
                s_d.ctl1 = bus_i.wdata;
            end else if (bus_i.addr == `ISP_A_CTRL2) begin
                s_d.ctl2 = bus_i.wdata;
            end
        end

        // register reads; unmapped reads return zero
        if (bus_i.addr < 4'(`ISP_N_PRI)) begin
            rd_mux = s_q.pri[bus_i.addr];
        end else if (bus_i.addr == `ISP_A_CTRL1) begin
            rd_mux = s_q.ctl1;
        end else if (bus_i.addr == `ISP_A_CTRL2) begin
            rd_mux = s_q.ctl2;
        end else if (bus_i.addr == `ISP_A_STAT) begin
            for (int i = 0; i < `ISP_N_PIN; i++) begin
                rd_mux[7 - i] = s_q.irq_f[i];
            end
        end
        s_d.rdata = bus_i.rd ? rd_mux : 16'h0000;
        if (bus_i.rd && bus_i.addr == `ISP_A_STAT) begin
            // a flag seen as 1 may then be cleared by writing 0
            s_d.armed = s_d.armed | s_q.irq_f;
        end

        // event detection
        if (s_q.ctl1[`ISP_NMI_POL_BIT]) begin
            nmi_edge = s_q.nmi_sy[1] && !s_q.nmi_old;
        end else begin
            nmi_edge = !s_q.nmi_sy[1] && s_q.nmi_old;
        end
        if (nmi_edge) begin
            s_d.nmi_f = 1'b1;
        end
        if (brk_match && !s_q.brk_old) begin
            s_d.brk_f = 1'b1;
        end
        if (dbg_irq_cmd && !s_q.dbg_old) begin
            s_d.dbg_f = 1'b1;
        end
        for (int i = 0; i < `ISP_N_PIN; i++) begin
            md = pin_mode(s_q.ctl1, s_q.ctl2, i);
            case (md)
                ISP_MD_LOW: begin
                    s_d.irq_f[i] = !s_q.irq_s2[i];
                    s_d.armed[i] = 1'b0;
                end
                ISP_MD_FALL: begin
                    if (s_q.irq_old[i] && !s_q.irq_s2[i]) begin
                        s_d.irq_f[i] = 1'b1;
                    end
                end
                ISP_MD_RISE: begin
                    if (!s_q.irq_old[i] && s_q.irq_s2[i]) begin
                        s_d.irq_f[i] = 1'b1;
                    end
                end
                ISP_MD_BOTH: begin
                    if (s_q.irq_old[i] != s_q.irq_s2[i]) begin
                        s_d.irq_f[i] = 1'b1;
                    end
                end
                default: begin
                    s_d.irq_f[i] = s_q.irq_f[i];
                end
            endcase
        end

        // candidates in fixed default order: index is the source number
        // five kinds: nmi, break, debug, pins, peripherals; levels span 0 to 16
        pend[0] = s_q.nmi_f;
        lvl[0] = `ISP_LVL_NMI;
        pend[1] = s_q.brk_f;
        lvl[1] = `ISP_LVL_FIX;
        pend[2] = s_q.dbg_f;
        lvl[2] = `ISP_LVL_FIX;
        for (int i = 0; i < `ISP_N_PIN; i++) begin
            pend[3 + i] = s_q.irq_f[i];
            lvl[3 + i] = {1'b0, pri_of(s_q.pri, i)};
        end
        for (int i = 0; i < NPER; i++) begin
            pend[11 + i] = periph_req[i];
            lvl[11 + i] = {1'b0, pri_of(s_q.pri, `ISP_PER_FIELD0 + i)};
        end
        // strict compare: level 0 never wins, ties keep the smaller number
        for (int k = 0; k < NSRC; k++) begin
            if (pend[k] && lvl[k] > best_lvl) begin
                best_lvl = lvl[k];
                best_src = 6'(k);
                found = 1'b1;
            end
        end

        // the taken source drops out one cycle later; hold off re-presenting it
        s_d.cpu.valid = found && !take;
        s_d.cpu.level = best_lvl;
        s_d.cpu.src = best_src;
        s_d.cpu.taken = take;
        if (take) begin
            if (s_q.cpu.level == `ISP_LVL_NMI) begin
                s_d.cpu.new_mask = `ISP_MASK_FIX;
            end else begin
                s_d.cpu.new_mask = s_q.cpu.level[3:0];
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            s_q <= ST_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign rdata_o = s_q.rdata;
    assign cpu_o = s_q.cpu;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);

    logic clr0_ok;
    logic take_irq0;
    isp_mode_t md0;
    assign clr0_ok = clr_ok[0];
    assign take_irq0 = take && s_q.cpu.src == `ISP_SRC_IRQ0;
    assign md0 = pin_mode(s_q.ctl1, s_q.ctl2, 0);

    a_nmi_always: assert property (
        s_q.nmi_f && !take |=> s_q.cpu.valid && s_q.cpu.level == `ISP_LVL_NMI
    ) else $error("pending nmi not presented at level 16");

    a_zero_masked: assert property (
        s_q.cpu.valid |-> s_q.cpu.level != 5'h00
    ) else $error("level 0 request presented");

    a_above_mask: assert property (
        s_q.cpu.valid |-> s_q.cpu.level > {1'b0, $past(cpu_i.mask_level)}
    ) else $error("request not above mask level");

    a_mask_load: assert property (
        take |=> s_q.cpu.taken && s_q.cpu.new_mask ==
            (($past(s_q.cpu.level) == `ISP_LVL_NMI) ? `ISP_MASK_FIX : $past(s_q.cpu.level[3:0]))
    ) else $error("wrong mask level after accept");

    a_brk_hold: assert property (
        s_q.brk_f && !(take && s_q.cpu.src == `ISP_SRC_BRK) |=> s_q.brk_f
    ) else $error("breakpoint request lost before accept");

    a_low_follow: assert property (
        md0 == ISP_MD_LOW ##1 md0 == ISP_MD_LOW |-> s_q.irq_f[0] == !$past(s_q.irq_s2[0])
    ) else $error("low level flag does not follow pin");

    a_fall_latch: assert property (
        md0 == ISP_MD_FALL && s_q.irq_old[0] && !s_q.irq_s2[0] |=> s_q.irq_f[0]
    ) else $error("falling edge not latched");

    a_rise_latch: assert property (
        md0 == ISP_MD_RISE && !s_q.irq_old[0] && s_q.irq_s2[0] |=> s_q.irq_f[0]
    ) else $error("rising edge not latched");

    a_clear_cause: assert property (
        $past(md0) != ISP_MD_LOW && $fell(s_q.irq_f[0]) |-> $past(clr0_ok) || $past(take_irq0)
    ) else $error("edge flag cleared without cause");

    a_reset_pri: assert property (
        $past(sys_rst) |-> s_q.pri == '0
    ) else $error("priority not zero after reset");

endmodule : isp_ctrl

/* File: core/isp_params.svh */
`ifndef ISP_PARAMS_SVH
`define ISP_PARAMS_SVH
// Notes on behaviour
// - a 4-bit priority field value is the level itself, 0 lowest, 15 highest.
// - five source kinds: non-maskable pin, breakpoint, debug port, pins, peripherals.
// - every request carries a level from 0 (lowest) to 16 (highest).
// - a source at level 0 is masked and never accepted.
// - the non-maskable request is level 16 and always accepted.
// - non-maskable pin is edge detected; a control one bit picks rising or falling.
// - taking the non-maskable request sets the cpu mask level to 15.
// - per pin, a sense bit and 2-bit edge field pick low level, falling, rising or both edges.
// - each external pin has its own priority 0 to 15 in registers a and b.
// - in low level mode the request stands exactly while the pin is low.
// - in low level mode the status flag shows the current request level.
// - in falling mode a high-to-low pin change raises the request.
// - an edge request stays latched until the cpu takes it or a status write clears it.
// - an edge flag clears on a write of 0 after it was read as 1.
// - taking a pin request loads the cpu mask with its programmed priority.
// - every peripheral request has its own distinct source number.
// - each peripheral has a programmable priority 0 to 15 in registers c to j.
// - taking a peripheral request loads the cpu mask with its priority.
// - breakpoint request is level 15, raised on a match, sets the mask to 15.
// - breakpoint request is edge detected and held until taken.
// - debug port request is level 15, raised by a serial command, sets mask 15.
// - debug port request is edge detected and held until taken.
// - sources of equal level rank by source number, smaller wins, fixed.
// - reset sets every pin and peripheral priority to level 0.
// - simultaneous equal-level requests resolve in the fixed default order.
`define ISP_N_PRI 10
`define ISP_A_CTRL1 4'hA
`define ISP_A_CTRL2 4'hB
`define ISP_A_STAT 4'hC
`define ISP_PRI_RST 16'h0000
`define ISP_CTRL_RST 16'h0000
`define ISP_NMI_POL_BIT 15
`define ISP_LVL_NMI 5'h10
`define ISP_LVL_FIX 5'h0F
`define ISP_MASK_FIX 4'hF
`define ISP_SRC_NMI 6'h00
`define ISP_SRC_BRK 6'h01
`define ISP_SRC_DBG 6'h02
`define ISP_SRC_IRQ0 6'h03
`define ISP_SRC_PER0 6'h0B
`define ISP_N_PIN 8
`define ISP_PER_FIELD0 8
`endif

/* File: core/isp_pkg.sv */
package isp_pkg;
    typedef enum logic [1:0] {
        ISP_MD_LOW = 2'b00,
        ISP_MD_FALL = 2'b01,
        ISP_MD_RISE = 2'b10,
        ISP_MD_BOTH = 2'b11
    } isp_mode_t;
    typedef struct packed {
        logic [3:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } isp_bus_t;
    typedef struct packed {
        logic [3:0] mask_level;
        logic accept;
    } isp_cpu_in_t;
    typedef struct packed {
        logic valid;
        logic [4:0] level;
        logic [5:0] src;
        logic [3:0] new_mask;
        logic taken;
    } isp_cpu_out_t;
endpackage : isp_pkg

/* File: tb/isp_cpu_model.sv */
module isp_cpu_model (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire isp_pkg::isp_cpu_out_t cpu_o,
    input wire logic take_en,
    input wire logic slow,
    input wire logic mask_wr,
    input wire logic [3:0] mask_set,
    output isp_pkg::isp_cpu_in_t cpu_i
);
    import isp_pkg::*;
    logic [1:0] age_q;
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            cpu_i <= '0;
            age_q <= 2'h0;
        end else begin
            // slow mode leaves a pending request waiting two extra cycles
            age_q <= cpu_o.valid ? (age_q == 2'h2 ? age_q : age_q + 2'h1) : 2'h0;
            cpu_i.accept <= take_en && cpu_o.valid && !cpu_i.accept
                && (!slow || age_q == 2'h2);
            if (cpu_o.taken) begin
                cpu_i.mask_level <= cpu_o.new_mask;
            end else if (mask_wr) begin
                cpu_i.mask_level <= mask_set;
            end
        end
    end
endmodule : isp_cpu_model

/* File: tb/isp_ctrl_tb_top.sv */
module isp_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import isp_pkg::*;
    typedef struct packed {
        logic [3:0] req;
        logic [15:0] pri;
        logic [3:0] msk;
        logic ok;
        logic [4:0] lvl;
        logic [5:0] src;
    } isp_row_t;
    isp_row_t rows [7] = '{
        '{4'h1, 16'h5000, 4'h0, 1'h1, 5'h05, 6'h0B},
        '{4'h1, 16'h0000, 4'h0, 1'h0, 5'h00, 6'h00},
        '{4'h3, 16'h3700, 4'h0, 1'h1, 5'h07, 6'h0C},
        '{4'h3, 16'h7700, 4'h0, 1'h1, 5'h07, 6'h0B},
        '{4'h8, 16'h000F, 4'hE, 1'h1, 5'h0F, 6'h0E},
        '{4'h8, 16'h0005, 4'h5, 1'h0, 5'h00, 6'h00},
        '{4'h8, 16'h0005, 4'h4, 1'h1, 5'h05, 6'h0E}};
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    isp_bus_t bus = '0;
    logic [15:0] rdata;
    logic nmi = 1'b1;
    logic [7:0] pins = 8'hFF;
    logic brk = 1'b0;
    logic dbg = 1'b0;
    logic [3:0] preq = 4'h0;
    logic take = 1'b0;
    logic slow = 1'b0;
    logic mwr = 1'b0;
    logic [3:0] mset = 4'h0;
    isp_cpu_in_t cpu_i;
    isp_cpu_out_t cpu_o;
    int err_total = 0;
    int num_checks = 0;
    logic [15:0] v;
    always #2.5 mclk = ~mclk;
    isp_ctrl #(.NPER(4)) u_isp_ctrl (.mclk(mclk), .sys_rst(sys_rst), .bus_i(bus),
        .rdata_o(rdata), .nmi_pin(nmi), .irq_pins_n(pins), .brk_match(brk),
        .dbg_irq_cmd(dbg), .periph_req(preq), .cpu_i(cpu_i), .cpu_o(cpu_o));
    isp_cpu_model u_isp_cpu_model (.mclk(mclk), .sys_rst(sys_rst), .cpu_o(cpu_o),
        .take_en(take), .slow(slow), .mask_wr(mwr), .mask_set(mset), .cpu_i(cpu_i));
    // ************************************************************
    // bus and check tasks
    // ************************************************************
    task automatic complete_run;
        if (err_total == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : complete_run
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : tick
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge mclk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge mclk);
        bus.wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a);
        @(posedge mclk);
        bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge mclk);
        bus.rd <= 1'b0;
        #1 v = rdata;
    endtask : rd
    task automatic mask(input logic [3:0] m);
        @(posedge mclk);
        mwr <= 1'b1;
        mset <= m;
        @(posedge mclk);
        mwr <= 1'b0;
    endtask : mask
    task automatic pin(input logic [7:0] p);
        @(posedge mclk);
        pins <= p;
        tick(6);
    endtask : pin
    // a bounded wait; running out ends the run
    task automatic wait_for(input logic sel);
        int n = 0;
        while ((sel ? cpu_o.taken : cpu_o.valid) !== 1'b1 && n < 50) begin
            tick(1);
            n++;
        end
        if ((sel ? cpu_o.taken : cpu_o.valid) !== 1'b1) begin
            err_total++;
            $display("wrong value at %0t: cpu link wait ran out", $time);
            complete_run();
        end
    endtask : wait_for
    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        tick(12);
        sys_rst <= 1'b0;
        for (int a = 0; a < 16; a++) begin
            rd(a[3:0]);
            chk(v, 16'h0000);
        end
        wr(4'h3, 16'hA5C3);
        rd(4'h3);
        chk(v, 16'hA5C3);
        foreach (rows[i]) begin
            wr(4'h2, rows[i].pri);
            mask(rows[i].msk);
            preq <= rows[i].req;
            tick(4);
            chk(cpu_o.valid, rows[i].ok);
            if (rows[i].ok) begin
                chk(cpu_o.level, rows[i].lvl);
                chk(cpu_o.src, rows[i].src);
            end
            @(posedge mclk);
            preq <= 4'h0;
        end
        take <= 1'b1;
        for (int k = 0; k < 2; k++) begin
            wr(4'hA, k ? 16'h8000 : 16'h0000);
            mask(4'hF);
            nmi <= k[0];
            wait_for(1'b0);
            chk(cpu_o.level, 16'h0010);
            chk(cpu_o.src, 16'h0000);
            wait_for(1'b1);
            chk(cpu_o.new_mask, 16'h000F);
        end
        mask(4'h0);
        nmi <= 1'b0;
        tick(8);
        chk(cpu_o.valid, 16'h0000);
        slow <= 1'b1;
        for (int k = 0; k < 2; k++) begin
            mask(4'hE);
            brk <= (k == 0);
            dbg <= (k == 1);
            @(posedge mclk);
            brk <= 1'b0;
            dbg <= 1'b0;
            wait_for(1'b0);
            chk(cpu_o.level, 16'h000F);
            chk(cpu_o.src, k + 1);
            wait_for(1'b1);
            chk(cpu_o.new_mask, 16'h000F);
        end
        @(posedge mclk);
        take <= 1'b0;
        mask(4'h0);
        wr(4'h0, 16'h9600);
        wr(4'hA, 16'h0080);
        wr(4'hB, 16'h4000);
        pin(8'hFE);
        pin(8'hFF);
        chk(cpu_o.level, 16'h0009);
        chk(cpu_o.src, 16'h0003);
        rd(4'hC);
        chk(v, 16'h0080);
        wr(4'hC, 16'h0000);
        tick(3);
        chk(cpu_o.valid, 16'h0000);
        wr(4'hB, 16'h8000);
        pin(8'hFE);
        chk(cpu_o.valid, 16'h0000);
        pin(8'hFF);
        chk(cpu_o.valid, 16'h0001);
        take <= 1'b1;
        wait_for(1'b1);
        chk(cpu_o.new_mask, 16'h0009);
        rd(4'hC);
        chk(v, 16'h0000);
        take <= 1'b0;
        mask(4'h0);
        wr(4'hB, 16'hC000);
        pin(8'hFE);
        chk(cpu_o.valid, 16'h0001);
        rd(4'hC);
        chk(v, 16'h0080);
        wr(4'hC, 16'h0000);
        tick(3);
        chk(cpu_o.valid, 16'h0000);
        pin(8'hFF);
        chk(cpu_o.valid, 16'h0001);
        wr(4'hA, 16'h0000);
        mask(4'h0);
        pin(8'hFD);
        chk(cpu_o.level, 16'h0006);
        chk(cpu_o.src, 16'h0004);
        rd(4'hC);
        chk(v, 16'h0040);
        pin(8'hFF);
        chk(cpu_o.valid, 16'h0000);
        rd(4'hC);
        chk(v, 16'h0000);
        wr(4'h2, 16'h5000);
        take <= 1'b1;
        preq <= 4'h1;
        wait_for(1'b1);
        chk(cpu_o.new_mask, 16'h0005);
        complete_run();
    end
endmodule : isp_ctrl_tb_top
